// file: hdl/dbapr_top.sv
// Top of the bank activate/precharge/refresh model: command decode, banks,
// refresh engine and APB register slave.
// Assumes commands sampled at pclk rising edges; APB master in the same domain.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "dbapr_cfg.svh"
module dbapr_top #(
   parameter int NBG = 2,
   parameter int NBA = 4,
   parameter int RP_CYC = `DBAPR_RP_CYC,
   parameter int AP_CYC = `DBAPR_AP_CYC,
   parameter int RFC_CYC = `DBAPR_RFC_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cs_n,
   input wire logic act_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] bg,
   input wire logic [1:0] ba,
   input wire logic [17:0] addr,
   input wire logic refi_tick,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [NBG*NBA-1:0] bank_open,
   output logic refresh_busy,
   output logic protocol_err
);
   localparam int NB = NBG * NBA;
   ////////////////////////////////////////////////////////////////
   // Command decode; act_n low turns the strobes into row address bits
   logic sel;
   logic c_act;
   logic c_ref;
   logic c_pre;
   logic c_rd;
   logic c_wr;
   logic ap;
   logic [2:0] bidx;
   assign sel = !cs_n;
   assign c_act = sel && !act_n;
   assign c_ref = sel && act_n && !ras_n && !cas_n && we_n;
   assign c_pre = sel && act_n && !ras_n && cas_n && !we_n;
   assign c_rd = sel && act_n && ras_n && !cas_n && we_n;
   assign c_wr = sel && act_n && ras_n && !cas_n && !we_n;
   assign ap = addr[10];
   assign bidx = {bg[0], ba};
   ////////////////////////////////////////////////////////////////
   // Configuration registers
   logic [31:0] ctrl_q;
   logic [5:0] post_lim;
   logic [1:0] rmode;
   assign rmode = ctrl_q[1:0];
   // Mode 0 is 1X, 1 is 2X, 2 is 4X
   assign post_lim = (rmode == 2'd2) ? 6'd32 : (rmode == 2'd1) ? 6'd16 : 6'd8;
   ////////////////////////////////////////////////////////////////
   // Bank trackers, one per group and bank
   logic [NB-1:0] b_open;
   logic [NB-1:0] b_busy;
   dbapr_bank_if bif [NB] ();
   for (genvar i = 0; i < NB; i++) begin : g_bank
      assign bif[i].act = c_act && !c_ref && (bidx == 3'(i));
      // All-bank form when A10 set
      assign bif[i].pre = c_pre && (ap || bidx == 3'(i));
      // Auto precharge only touches its own bank; others proceed
      assign bif[i].rdwr_ap = (c_rd || c_wr) && ap && (bidx == 3'(i));
      assign bif[i].row = addr;
      assign b_open[i] = bif[i].is_open;
      assign b_busy[i] = bif[i].busy;
      dbapr_bank #(.RP_CYC(RP_CYC), .AP_CYC(AP_CYC)) u_bank (
         .pclk(pclk),
         .presetn(presetn),
         .b(bif[i])
      );
   end
   ////////////////////////////////////////////////////////////////
   // Refresh engine
   logic rf_busy;
   logic [15:0] rf_cnt;
   logic signed [7:0] rf_cred;
   logic rf_go;
   assign rf_go = c_ref && !rf_busy;
   dbapr_refresh #(.RFC_CYC(RFC_CYC)) u_ref (
      .pclk(pclk),
      .presetn(presetn),
      .ref_go(rf_go),
      .tick(refi_tick),
      .lim(post_lim),
      .busy(rf_busy),
      .rcnt(rf_cnt),
      .credit(rf_cred)
   );
   ////////////////////////////////////////////////////////////////
   // Controller misuse detection; sticky, cleared by write to status
   logic viol_act_open;
   logic viol_act_busy;
   logic viol_rw_idle;
   logic viol_ref_banks;
   logic viol_ref_busy;
   logic viol_post;
   logic [5:0] viol_now;
   logic [5:0] err_q;
   logic [NB-1:0] sel_mask;
   assign sel_mask = NB'(1) << bidx;
   assign viol_act_open = c_act && |(b_open & sel_mask);
   assign viol_act_busy = c_act && |(b_busy & sel_mask);
   assign viol_rw_idle = (c_rd || c_wr) && !(|(b_open & sel_mask));
   assign viol_ref_banks = c_ref && (|b_open || |b_busy);
   assign viol_ref_busy = rf_busy && sel;
   assign viol_post = (rf_cred < -$signed({2'b00, post_lim}));
   assign viol_now = {viol_post, viol_ref_busy, viol_ref_banks, viol_rw_idle,
      viol_act_busy, viol_act_open};
   ////////////////////////////////////////////////////////////////
   // APB decode
   logic wr_en;
   logic rd_en;
   logic hit;
   logic [31:0] rd_mux;
   logic [7:0] rpr_page;
   logic [7:0] mac_page;
   logic [17:0] bif_row_sel;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign rpr_page = {1'b1, 1'b1, 6'h00};
   assign mac_page = {4'h0, `DBAPR_MAC_UNLIMITED};
   assign hit = (paddr == `DBAPR_OFF_CTRL) || (paddr == `DBAPR_OFF_STAT) ||
      (paddr == `DBAPR_OFF_OPEN) || (paddr == `DBAPR_OFF_RPR) ||
      (paddr == `DBAPR_OFF_MAC) || (paddr == `DBAPR_OFF_ROW) ||
      (paddr == `DBAPR_OFF_CRED) || (paddr == `DBAPR_OFF_RCNT);
   assign rd_mux =
      (paddr == `DBAPR_OFF_CTRL) ? ctrl_q :
      (paddr == `DBAPR_OFF_STAT) ? {26'h0, err_q} :
      (paddr == `DBAPR_OFF_OPEN) ? {{(32-NB){1'b0}}, b_open} :
      (paddr == `DBAPR_OFF_RPR) ? {24'h0, rpr_page} :
      (paddr == `DBAPR_OFF_MAC) ? {24'h0, mac_page} :
      (paddr == `DBAPR_OFF_ROW) ? {14'h0, bif_row_sel} :
      (paddr == `DBAPR_OFF_CRED) ? {{24{rf_cred[7]}}, rf_cred} :
      (paddr == `DBAPR_OFF_RCNT) ? {16'h0, rf_cnt} : 32'h0000_0000;
   // Row readback for the bank chosen in ctrl bits 6:4
   logic [17:0] rows [NB];
   for (genvar j = 0; j < NB; j++) begin : g_rows
      assign rows[j] = bif[j].open_row;
   end
   assign bif_row_sel = rows[ctrl_q[6:4]];
   ////////////////////////////////////////////////////////////////
   // APB slave: no wait states, read data registered in setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         if (rd_en) begin
            prdata <= rd_mux;
         end
      end
   end
   // Control write; status bits clear on write-one, new event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `DBAPR_CTRL_RST;
         err_q <= 6'h00;
      end else begin
         if (wr_en && pready && paddr == `DBAPR_OFF_CTRL) begin
            ctrl_q <= {25'h0, pwdata[6:0]};
         end
         if (wr_en && pready && paddr == `DBAPR_OFF_STAT) begin
            err_q <= (err_q & ~pwdata[5:0]) | viol_now;
         end else begin
            err_q <= err_q | viol_now;
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   // Registered status outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_open <= '0;
         refresh_busy <= 1'b0;
         protocol_err <= 1'b0;
      end else begin
         bank_open <= b_open;
         refresh_busy <= rf_busy;
         protocol_err <= |(err_q | viol_now);
      end
   end
endmodule : dbapr_top

// file: hdl/dbapr_cfg.svh
// Constants for the bank activate/precharge/refresh model: offsets, fields, timing.
// Assumes inclusion by bare name from hdl/ and test/ files.
`ifndef DBAPR_CFG_SVH
`define DBAPR_CFG_SVH
`define DBAPR_OFF_CTRL 12'h000
`define DBAPR_OFF_STAT 12'h004
`define DBAPR_OFF_OPEN 12'h008
`define DBAPR_OFF_RPR 12'h00C
`define DBAPR_OFF_MAC 12'h010
`define DBAPR_OFF_ROW 12'h014
`define DBAPR_OFF_CRED 12'h018
`define DBAPR_OFF_RCNT 12'h01C
`define DBAPR_BIT_HARD 7
`define DBAPR_BIT_SOFT 6
`define DBAPR_MAC_UNLIMITED 4'h8
`define DBAPR_CTRL_RST 32'h0000_00C0
`define DBAPR_CLK_NS 4
`define DBAPR_RP_NS 15
`define DBAPR_RFC_NS 350
`define DBAPR_AP_NS 20
`define DBAPR_CYC_MIN(ns) (((ns) + `DBAPR_CLK_NS - 1) / `DBAPR_CLK_NS)
`define DBAPR_RP_CYC `DBAPR_CYC_MIN(`DBAPR_RP_NS)
`define DBAPR_RFC_CYC `DBAPR_CYC_MIN(`DBAPR_RFC_NS)
`define DBAPR_AP_CYC `DBAPR_CYC_MIN(`DBAPR_AP_NS)
`endif

// file: hdl/dbapr_pkg.sv
// Types shared by the bank activate/precharge/refresh model.
// Assumes nothing beyond a SystemVerilog compiler.
package dbapr_pkg;
   typedef enum logic [2:0] {
      DBAPR_CMD_DES,
      DBAPR_CMD_ACT,
      DBAPR_CMD_PRE,
      DBAPR_CMD_PREA,
      DBAPR_CMD_RD,
      DBAPR_CMD_WR,
      DBAPR_CMD_REF,
      DBAPR_CMD_OTHER
   } dbapr_cmd_e;
   typedef enum logic [1:0] {
      DBAPR_BK_IDLE,
      DBAPR_BK_OPEN,
      DBAPR_BK_AUTOPRE,
      DBAPR_BK_PRECHG
   } dbapr_bank_e;
   typedef enum logic [1:0] {
      DBAPR_RF_IDLE,
      DBAPR_RF_BUSY
   } dbapr_ref_e;
endpackage : dbapr_pkg

// file: hdl/dbapr_bank_if.sv
// Carrier between the top and each bank tracker: decoded command and bank status.
// Assumes one clock domain, pclk.
`timescale 1ns/100ps
interface dbapr_bank_if;
   logic act;
   logic pre;
   logic rdwr_ap;
   logic [17:0] row;
   logic is_open;
   logic busy;
   logic [17:0] open_row;
   modport ctl (output act, output pre, output rdwr_ap, output row,
      input is_open, input busy, input open_row);
   modport bank (input act, input pre, input rdwr_ap, input row,
      output is_open, output busy, output open_row);
endinterface : dbapr_bank_if

// file: hdl/dbapr_bank.sv
// One bank's row state: open row, auto precharge delay, precharge timer.
// Assumes commands arrive as one-cycle strobes via the bank carrier.
`timescale 1ns/100ps
`include "dbapr_cfg.svh"
module dbapr_bank #(
   parameter int RP_CYC = `DBAPR_RP_CYC,
   parameter int AP_CYC = `DBAPR_AP_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   dbapr_bank_if.bank b
);
   dbapr_pkg::dbapr_bank_e st_q;
   logic [7:0] tmr_q;
   logic [17:0] row_q;
   assign b.is_open = (st_q == dbapr_pkg::DBAPR_BK_OPEN) ||
      (st_q == dbapr_pkg::DBAPR_BK_AUTOPRE);
   assign b.busy = (st_q == dbapr_pkg::DBAPR_BK_PRECHG);
   assign b.open_row = row_q;
   ////////////////////////////////////////////////////////////////
   // State per bank; precharge restarts the timer each time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= dbapr_pkg::DBAPR_BK_IDLE;
         tmr_q <= 8'h00;
         row_q <= 18'h0_0000;
      end else begin
         case (st_q)
            dbapr_pkg::DBAPR_BK_IDLE: begin
               if (b.act) begin
                  st_q <= dbapr_pkg::DBAPR_BK_OPEN;
                  row_q <= b.row;
               end else if (b.pre) begin
                  st_q <= dbapr_pkg::DBAPR_BK_PRECHG;
                  tmr_q <= RP_CYC[7:0];
               end
            end
            dbapr_pkg::DBAPR_BK_OPEN: begin
               if (b.pre) begin
                  st_q <= dbapr_pkg::DBAPR_BK_PRECHG;
                  tmr_q <= RP_CYC[7:0];
               end else if (b.rdwr_ap) begin
                  // Restore or write store finishes before the row closes
                  st_q <= dbapr_pkg::DBAPR_BK_AUTOPRE;
                  tmr_q <= AP_CYC[7:0];
               end
            end
            dbapr_pkg::DBAPR_BK_AUTOPRE: begin
               if (b.pre || tmr_q <= 8'h01) begin
                  st_q <= dbapr_pkg::DBAPR_BK_PRECHG;
                  tmr_q <= RP_CYC[7:0];
               end else begin
                  tmr_q <= tmr_q - 8'h01;
               end
            end
            dbapr_pkg::DBAPR_BK_PRECHG: begin
               if (b.pre) begin
                  tmr_q <= RP_CYC[7:0];
               end else if (tmr_q <= 8'h01) begin
                  st_q <= dbapr_pkg::DBAPR_BK_IDLE;
                  tmr_q <= 8'h00;
               end else begin
                  tmr_q <= tmr_q - 8'h01;
               end
            end
            default: st_q <= dbapr_pkg::DBAPR_BK_IDLE;
         endcase
      end
   end
endmodule : dbapr_bank

// file: hdl/dbapr_refresh.sv
// Refresh engine: internal row counter, busy timer, postpone/pull-in credit.
// Assumes a one-cycle refresh strobe and a pulse per elapsed average interval.
`timescale 1ns/100ps
`include "dbapr_cfg.svh"
module dbapr_refresh #(
   parameter int RFC_CYC = `DBAPR_RFC_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ref_go,
   input wire logic tick,
   input wire logic [5:0] lim,
   output logic busy,
   output logic [15:0] rcnt,
   output logic signed [7:0] credit
);
   dbapr_pkg::dbapr_ref_e st_q;
   logic [8:0] tmr_q;
   logic [15:0] rcnt_q;
   logic signed [7:0] cred_q;
   logic signed [7:0] cred_d;
   logic signed [7:0] lim_s;
   assign busy = (st_q == dbapr_pkg::DBAPR_RF_BUSY);
   assign rcnt = rcnt_q;
   assign credit = cred_q;
   assign lim_s = $signed({2'b00, lim});
   // Credit: refreshes ahead (+) or owed (-); pull-in beyond limit earns nothing
   always_comb begin
      cred_d = cred_q + (ref_go ? 8'sd1 : 8'sd0) - (tick ? 8'sd1 : 8'sd0);
      if (cred_d > lim_s) begin
         cred_d = lim_s;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Busy for the refresh cycle; row address from own counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= dbapr_pkg::DBAPR_RF_IDLE;
         tmr_q <= 9'h000;
         rcnt_q <= 16'h0000;
         cred_q <= 8'sd0;
      end else begin
         cred_q <= cred_d;
         case (st_q)
            dbapr_pkg::DBAPR_RF_IDLE: begin
               if (ref_go) begin
                  st_q <= dbapr_pkg::DBAPR_RF_BUSY;
                  tmr_q <= RFC_CYC[8:0];
                  rcnt_q <= rcnt_q + 16'h0001;
               end
            end
            dbapr_pkg::DBAPR_RF_BUSY: begin
               if (tmr_q <= 9'h001) begin
                  st_q <= dbapr_pkg::DBAPR_RF_IDLE;
               end else begin
                  tmr_q <= tmr_q - 9'h001;
               end
            end
            default: st_q <= dbapr_pkg::DBAPR_RF_IDLE;
         endcase
      end
   end
endmodule : dbapr_refresh

// file: test/dbapr_chk.sv
// Checker on the top's ports: row open/close, auto precharge, refresh, readouts.
// Assumes a bind to every top instance; one clock domain.
`timescale 1ns/100ps
`include "dbapr_cfg.svh"
module dbapr_chk #(
   parameter int NBG = 2,
   parameter int NBA = 4,
   parameter int RFC_CYC = 88
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cs_n,
   input wire logic act_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] bg,
   input wire logic [1:0] ba,
   input wire logic [17:0] addr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [NBG*NBA-1:0] bank_open,
   input wire logic refresh_busy
);
   localparam int AP_MAX = 12;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Command decode as the device sees it
   wire cmd_act = !cs_n && !act_n;
   wire cmd_ref = !cs_n && act_n && !ras_n && !cas_n && we_n;
   wire cmd_pre = !cs_n && act_n && !ras_n && cas_n && !we_n;
   wire cmd_rdap = !cs_n && act_n && ras_n && !cas_n && addr[10];
   wire [2:0] idx = {bg[0], ba};
   wire rd_done = psel && penable && pready && !pwrite;
   logic [2:0] ap_q;
   int blen_q;
   // Bank of the last auto precharge; a later one would overwrite it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ap_q <= 3'h0;
      else if (cmd_rdap) ap_q <= idx;
   end
   // Length of the current refresh cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) blen_q <= 0;
      else if (refresh_busy) blen_q <= blen_q + 1;
      else blen_q <= 0;
   end
   ////////////////////////////////////////////////////////////////////////
   property p_act_open;
      cmd_act && !bank_open[idx] && !refresh_busy |-> ##2 bank_open[$past(idx, 2)];
   endproperty
   a_act_open: assert property (p_act_open) else $error("row did not open");
   property p_pre_close;
      cmd_pre && !addr[10] |-> ##2 !bank_open[$past(idx, 2)];
   endproperty
   a_pre_close: assert property (p_pre_close) else $error("bank not closed");
   property p_pre_all;
      cmd_pre && addr[10] |-> ##2 bank_open == '0;
   endproperty
   a_pre_all: assert property (p_pre_all) else $error("banks not all closed");
   property p_ap_close;
      cmd_rdap && bank_open[idx] |=> bank_open[ap_q] ##[1:AP_MAX] !bank_open[ap_q];
   endproperty
   a_ap_close: assert property (p_ap_close) else $error("auto precharge timing");
   property p_ref_busy;
      cmd_ref && !refresh_busy && bank_open == '0 |-> ##2 refresh_busy;
   endproperty
   a_ref_busy: assert property (p_ref_busy) else $error("refresh not started");
   property p_busy_src;
      $rose(refresh_busy) |-> $past(cmd_ref, 2);
   endproperty
   a_busy_src: assert property (p_busy_src) else $error("refresh without command");
   property p_busy_len;
      $fell(refresh_busy) |-> blen_q == RFC_CYC && bank_open == '0;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("refresh length or banks");
   property p_repair;
      rd_done && paddr == `DBAPR_OFF_RPR |-> prdata[7:6] == 2'b11;
   endproperty
   a_repair: assert property (p_repair) else $error("repair readout wrong");
   property p_limit;
      rd_done && paddr == `DBAPR_OFF_MAC |-> prdata[3:0] == 4'h8;
   endproperty
   a_limit: assert property (p_limit) else $error("limit code wrong");
   // Main scenarios reached
   c_ap: cover property (cmd_rdap && bank_open[idx]);
   c_ref: cover property (cmd_ref ##2 refresh_busy);
   c_ref_end: cover property ($fell(refresh_busy));
endmodule : dbapr_chk
bind dbapr_top dbapr_chk #(.NBG(NBG), .NBA(NBA), .RFC_CYC(RFC_CYC)) dbapr_chk_i (
   .pclk(pclk), .presetn(presetn), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
   .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .addr(addr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .bank_open(bank_open), .refresh_busy(refresh_busy));

// file: test/dbapr_ctl_model.sv
// Memory controller model: one command per call, then deselects.
// Assumes the bench calls its tasks; same clock as the device.
`timescale 1ns/100ps
module dbapr_ctl_model #(
   parameter int RFC_CYC = 88
) (
   input wire logic pclk,
   output logic cs_n,
   output logic act_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [1:0] bg,
   output logic [1:0] ba,
   output logic [17:0] addr,
   output logic refi_tick
);
   localparam int GAP = 6; // Above activate spacing and precharge time
   // Idle bus at time zero
   initial begin
      {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1F;
      {bg, ba, addr, refi_tick} = '0;
   end
   // Op is {act_n, ras_n, cas_n, we_n}; address shows inverse once released
   task automatic issue(input logic [3:0] op, input logic [2:0] bk, input logic [17:0] a);
      @(posedge pclk);
      cs_n <= 1'b0;
      {act_n, ras_n, cas_n, we_n} <= op;
      {bg, ba} <= {1'b0, bk};
      addr <= a;
      @(posedge pclk);
      cs_n <= 1'b1;
      addr <= ~a;
      repeat (op == 4'h9 ? RFC_CYC + 4 : GAP) @(posedge pclk);
   endtask : issue
   // One elapsed average interval
   task automatic tick;
      @(posedge pclk);
      refi_tick <= 1'b1;
      @(posedge pclk);
      refi_tick <= 1'b0;
   endtask : tick
endmodule : dbapr_ctl_model

// file: test/test_dram_bank_activate_precharge_refresh.sv
// Bench: APB register checks plus random row traffic, auto precharge, refresh.
// Assumes the controller model and the bound checker.
`timescale 1ns/100ps
`include "dbapr_cfg.svh"
module test_dram_bank_activate_precharge_refresh;
   localparam int RFC = 10; // Short refresh to keep the run brief
   localparam logic [3:0] ACT = 4'h7, PRE = 4'hA, RD = 4'hD, WR = 4'hC, REF = 4'h9;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, refresh_busy;
   logic protocol_err, cs_n, act_n, ras_n, cas_n, we_n, refi_tick, err_q;
   logic [1:0] bg, ba;
   logic [17:0] addr, row;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata_q, cnt0;
   logic [7:0] bank_open;
   logic [2:0] bk;
   int err_total, comparisons;
   dbapr_top #(.RFC_CYC(RFC)) dbapr_top_i (.pclk(pclk), .presetn(presetn), .cs_n(cs_n),
      .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba),
      .addr(addr), .refi_tick(refi_tick), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bank_open(bank_open), .refresh_busy(refresh_busy), .protocol_err(protocol_err));
   dbapr_ctl_model #(.RFC_CYC(RFC)) dbapr_ctl_model_i (.pclk(pclk), .cs_n(cs_n),
      .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba),
      .addr(addr), .refi_tick(refi_tick));
   ////////////////////////////////////////////////////////////////////////
   // Expected credit: pull-in saturates at the 1X limit, ticks count down
   function automatic logic [7:0] cred_exp(input int refs, input int ticks);
      return 8'((refs > 8 ? 8 : refs) - ticks);
   endfunction : cred_exp
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // APB transfer: setup, then access held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdata_q = prdata;
      err_q = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 20) begin
         err_total++;
         report_and_stop();
      end
   endtask : apb
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rdata_q & m);
   endtask : rd_chk
   ////////////////////////////////////////////////////////////////////////
   // Free-running clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      err_total = 0;
      comparisons = 0;
      void'($urandom(31079));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("repair", `DBAPR_OFF_RPR, 32'hFFFFFFFF, 32'h000000C0);
      rd_chk("limit", `DBAPR_OFF_MAC, 32'h0000000F, 32'h00000008);
      rd_chk("ctrl", `DBAPR_OFF_CTRL, 32'hFFFFFFFF, `DBAPR_CTRL_RST);
      apb(1'b0, 12'h040, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err_q});
      chk("unmapped data", 32'h0, rdata_q);
      // Random rows; second precharge hits an idle bank
      for (int i = 0; i < 6; i++) begin
         bk = 3'($urandom);
         row = 18'($urandom);
         dbapr_ctl_model_i.issue(ACT, bk, row);
         apb(1'b1, `DBAPR_OFF_CTRL, {25'h0, bk, 4'h0});
         rd_chk("open row", `DBAPR_OFF_ROW, 32'h3FFFF, {14'h0, row});
         rd_chk("open map", `DBAPR_OFF_OPEN, 32'hFF, 32'h1 << bk);
         dbapr_ctl_model_i.issue(PRE, bk, 18'($urandom) & 18'h3FBFF);
         rd_chk("closed map", `DBAPR_OFF_OPEN, 32'hFF, 32'h0);
         dbapr_ctl_model_i.issue(PRE, bk, 18'h0);
         rd_chk("status", `DBAPR_OFF_STAT, 32'h3F, 32'h0);
      end
      // Auto precharge with other bank read meanwhile
      dbapr_ctl_model_i.issue(ACT, 3'h1, 18'h00123);
      dbapr_ctl_model_i.issue(ACT, 3'h6, 18'h2A5A5);
      dbapr_ctl_model_i.issue(RD, 3'h1, 18'h00400);
      dbapr_ctl_model_i.issue(RD, 3'h6, 18'h00000);
      rd_chk("ap map", `DBAPR_OFF_OPEN, 32'hFF, 32'h40);
      dbapr_ctl_model_i.issue(WR, 3'h6, 18'h00400);
      rd_chk("wr ap map", `DBAPR_OFF_OPEN, 32'hFF, 32'h0);
      rd_chk("ap status", `DBAPR_OFF_STAT, 32'h3F, 32'h0);
      chk("err pin idle", 32'h0, {31'h0, protocol_err});
      for (int k = 0; k < 4; k++) dbapr_ctl_model_i.issue(ACT, 3'(k * 3), 18'($urandom));
      dbapr_ctl_model_i.issue(PRE, 3'h0, 18'h00400);
      rd_chk("all closed", `DBAPR_OFF_OPEN, 32'hFF, 32'h0);
      // Refreshes: internal row counter, then pull-in and postpone credit
      apb(1'b0, `DBAPR_OFF_RCNT, 32'h0);
      cnt0 = rdata_q;
      // Ten refreshes stay below sixteen per two average intervals
      for (int i = 0; i < 10; i++) begin
         dbapr_ctl_model_i.issue(REF, 3'($urandom), 18'($urandom));
      end
      rd_chk("row count", `DBAPR_OFF_RCNT, 32'hFFFF, (cnt0 + 32'd10) & 32'hFFFF);
      rd_chk("pull-in", `DBAPR_OFF_CRED, 32'hFF, {24'h0, cred_exp(10, 0)});
      repeat (17) dbapr_ctl_model_i.tick();
      rd_chk("postpone", `DBAPR_OFF_CRED, 32'hFF, {24'h0, cred_exp(10, 17)});
      rd_chk("over limit", `DBAPR_OFF_STAT, 32'h20, 32'h20);
      chk("err pin set", 32'h1, {31'h0, protocol_err});
      // 2X mode allows sixteen owed, so the flag clears on write-one
      apb(1'b1, `DBAPR_OFF_CTRL, 32'h0000_0001);
      rd_chk("ctrl mode", `DBAPR_OFF_CTRL, 32'hFF, 32'h0000_0001);
      apb(1'b1, `DBAPR_OFF_STAT, 32'h0000_0020);
      rd_chk("2x limit", `DBAPR_OFF_STAT, 32'h3F, 32'h0);
      chk("err pin clear", 32'h0, {31'h0, protocol_err});
      report_and_stop();
   end
endmodule : test_dram_bank_activate_precharge_refresh
